// File: common/mcec_pkg.sv
/*
 * Package for the machine check error capture block: register offsets, field positions,
 * reset values, timing counts and carrier structs.
 * Assumes a 40 MHz clock and 32-bit APB access with one aligned word per register.
 */
package mcec_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] XBUF_STS_OFS   = 8'h00;
    localparam logic [7:0] EXEC_CTRL_OFS  = 8'h04;
    localparam logic [7:0] IC_STS_OFS     = 8'h08;
    localparam logic [7:0] IC_VADDR_OFS   = 8'h0C;
    localparam logic [7:0] L2_STS_OFS     = 8'h10;
    localparam logic [7:0] L2_IDX_OFS     = 8'h14;
    localparam logic [7:0] L2_SYN_OFS     = 8'h18;
    localparam logic [7:0] L2_CTRL_OFS    = 8'h1C;
    localparam logic [7:0] BUS_STS_OFS    = 8'h20;
    localparam logic [7:0] MCHK_INFO_OFS  = 8'h24;
    localparam logic [7:0] INT_STS_OFS    = 8'h28;
    localparam logic [7:0] INT_MASK_OFS   = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int XB_LOCK_BIT   = 0;
    localparam int XB_TAG_BIT    = 1;
    localparam int XB_DATA_BIT   = 2;
    localparam int EC_TMO_BIT    = 0;
    localparam int IC_LOCK_BIT   = 0;
    localparam int IC_TAG_BIT    = 1;
    localparam int IC_DATA_BIT   = 2;
    localparam int IC_EN_BIT     = 3;
    localparam int IC_LOST_BIT   = 4;
    localparam int L2_LOCK_BIT   = 0;
    localparam int L2_ADDR_BIT   = 1;
    localparam int L2_UNC_BIT    = 2;
    localparam int L2_LOST_BIT   = 3;
    localparam int L2C_ETM_BIT   = 0;
    localparam int BUS_WB_BIT    = 0;
    localparam int MI_RST_BIT    = 8;
    // Interrupt status bits
    localparam int EV_ASYNC      = 0;
    localparam int EV_SYNC       = 1;
    localparam int EV_SOFT       = 2;
    localparam int EV_HARD       = 3;
    localparam int EV_NUM        = 4;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ASYNC_MCHK_CODE      = 8'h01;
    localparam logic [7:0] SYNC_MCHK_CODE       = 8'h02;
    localparam logic [7:0] STRING_STATE_CODE    = 8'h03;
    localparam logic [7:0] IMPOSSIBLE_ADDR_CODE = 8'h04;
    localparam logic [1:0] STR_ILLEGAL          = 2'h3;
    localparam logic [31:0] ZERO_RST            = 32'h0000_0000;
    localparam logic [31:0] IC_STS_RST          = 32'h0000_0008;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 25;
    localparam int STALL_TMO_NS   = 50000;
    localparam int STALL_TMO_CYC  = STALL_TMO_NS / CLK_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        tag_perr;
        logic        pte_perr;
    } mcec_xbuf_type;

    typedef struct packed {
        logic        rd_hit;
        logic [17:0] drv_addr;
        logic [17:0] wr_addr;
        logic        sbe;
        logic        mbe;
        logic [15:0] index;
        logic [7:0]  syndrome;
        logic        flush_wb;
    } mcec_l2_type;

    typedef struct packed {
        logic        tag_perr;
        logic        data_perr;
        logic [28:0] qw_vaddr;
    } mcec_ic_type;

endpackage : mcec_pkg

// File: hdl/mcec_top.sv
/*
 * Machine check error capture: translation buffer parity, execute stall timeout, string
 * state check, instruction cache parity and level-two cache data errors, with APB registers.
 * Assumes all error inputs come from logic on clk_i and are one-cycle pulses or levels.
 */
// Overview of operation
// - A translation buffer tag or data parity error forces a microtrap and an async check.
// - The translation buffer lock flag stays set until software clears it.
// - A stage-three stall that outlasts the timeout raises an async check and a sticky flag.
// - The illegal fourth string state during a string move raises a machine check.
// - Fetch errors are caught before state changes so the restartable flag is reported one unless another check comes in the same cycle.
// - A pending sync check whose fetch is abandoned by branch or exception becomes a soft error.
// - A page table read error on a write may microtrap at any point in microcode.
// - Unlocked instruction cache parity errors capture the quadword address; all post a soft error.
// - Software can disable and flush the instruction cache; its lock stays until cleared.
// - A level-two hit whose driven and written addresses differ is an addressing error.
// - Multi-bit errors, and addressing with single-bit errors, are reported uncorrectable.
// - Level-two errors enter error transition mode; unlocked ones record index and syndrome, post soft.
// - A flush writeback of owned data whose error persists flags a writeback error.
// - A data RAM error while locked sets the lost flag and always posts an interrupt.
// - Error transition mode holds until software clears the control bit.
// - Lost level-two data always posts a hard error interrupt.
`timescale 1ns/10ps
module mcec_top (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // Error sources
    input  wire mcec_pkg::mcec_xbuf_type xbuf_i,
    input  wire logic                 stall_s3_i,
    input  wire logic                 string_move_i,
    input  wire logic [1:0]           string_state_i,
    input  wire logic                 impossible_addr_i,
    input  wire mcec_pkg::mcec_ic_type ic_i,
    input  wire mcec_pkg::mcec_l2_type l2_i,
    input  wire logic                 fetch_err_i,
    input  wire logic                 pte_wr_err_i,
    input  wire logic                 fetch_abandon_i,
    input  wire logic                 fetch_used_i,
    // Core side outputs
    output logic                      microtrap_o,
    output logic                      mchk_o,
    output logic      [7:0]           mchk_code_o,
    output logic                      restartable_flag_o,
    output logic                      ic_enable_o,
    output logic                      ic_flush_o,
    output logic                      error_transition_mode_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic [31:0] w1c;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign w1c   = pwdata_i;
    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_en && (paddr_i == ofs);
    endfunction : wr_at

    logic [2:0]  xb_sts_r;
    logic        ec_tmo_r;
    logic [4:0]  ic_sts_r;
    logic [28:0] ic_vaddr_r;
    logic [3:0]  l2_sts_r;
    logic [15:0] l2_idx_r;
    logic [7:0]  l2_syn_r;
    logic        etm_r;
    logic        bus_wb_r;
    localparam int EV_NUM_W = mcec_pkg::EV_NUM;
    logic [EV_NUM_W-1:0] int_sts_r;
    logic [EV_NUM_W-1:0] int_mask_r;

    // ------------------------------------------------------------
    // Translation buffer parity
    // ------------------------------------------------------------
    logic xb_err;
    assign xb_err = xbuf_i.tag_perr || xbuf_i.pte_perr;
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            xb_sts_r <= 3'h0;
        end else if (xb_err && !xb_sts_r[mcec_pkg::XB_LOCK_BIT]) begin
            xb_sts_r <= {xbuf_i.pte_perr, xbuf_i.tag_perr, 1'b1};
        end else if (wr_at(mcec_pkg::XBUF_STS_OFS)) begin
            xb_sts_r <= xb_sts_r & ~w1c[2:0];
        end
    end

    // ------------------------------------------------------------
    // Stall timeout
    // ------------------------------------------------------------
    localparam logic [11:0] TMO_LAST = 12'(mcec_pkg::STALL_TMO_CYC - 1);
    logic [11:0] stall_cnt_r;
    logic        tmo_hit;
    assign tmo_hit = stall_s3_i && (stall_cnt_r == TMO_LAST);
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stall_cnt_r <= 12'h000;
        end else if (!stall_s3_i || tmo_hit) begin
            stall_cnt_r <= 12'h000;
        end else begin
            stall_cnt_r <= stall_cnt_r + 12'h001;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ec_tmo_r <= 1'b0;
        end else if (tmo_hit) begin
            ec_tmo_r <= 1'b1;
        end else if (wr_at(mcec_pkg::EXEC_CTRL_OFS) && w1c[mcec_pkg::EC_TMO_BIT]) begin
            ec_tmo_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Instruction cache parity
    // ------------------------------------------------------------
    logic ic_err;
    logic ic_flush_r;
    assign ic_err = ic_sts_r[mcec_pkg::IC_EN_BIT] && (ic_i.tag_perr || ic_i.data_perr);
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ic_sts_r   <= mcec_pkg::IC_STS_RST[4:0];
            ic_vaddr_r <= 29'h0;
            ic_flush_r <= 1'b0;
        end else begin
            ic_flush_r <= wr_at(mcec_pkg::IC_STS_OFS) && w1c[5];
            if (wr_at(mcec_pkg::IC_STS_OFS)) begin
                ic_sts_r[mcec_pkg::IC_EN_BIT] <= w1c[mcec_pkg::IC_EN_BIT];
                ic_sts_r[2:0] <= ic_sts_r[2:0] & ~w1c[2:0];
                ic_sts_r[4]   <= ic_sts_r[4] & ~w1c[4];
            end
            if (ic_err && !ic_sts_r[mcec_pkg::IC_LOCK_BIT]) begin
                ic_sts_r[2:0] <= {ic_i.data_perr, ic_i.tag_perr, 1'b1};
                ic_vaddr_r    <= ic_i.qw_vaddr;
            end else if (ic_err) begin
                ic_sts_r[mcec_pkg::IC_LOST_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Level-two cache data errors
    // ------------------------------------------------------------
    logic l2_addr_mis;
    logic l2_unc;
    logic l2_bad;
    logic l2_err;
    logic l2_locked;
    assign l2_addr_mis = l2_i.rd_hit && (l2_i.drv_addr != l2_i.wr_addr);
    assign l2_unc = l2_i.rd_hit && (l2_i.mbe || (l2_addr_mis && l2_i.sbe));
    assign l2_bad = l2_addr_mis && !l2_unc;
    assign l2_err = l2_unc || l2_bad;
    assign l2_locked = l2_sts_r[mcec_pkg::L2_LOCK_BIT];
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            l2_sts_r <= 4'h0;
            l2_idx_r <= 16'h0;
            l2_syn_r <= 8'h0;
        end else if (l2_err && !l2_locked) begin
            l2_sts_r <= {1'b0, l2_unc, l2_bad, 1'b1};
            l2_idx_r <= l2_i.index;
            l2_syn_r <= l2_i.syndrome;
        end else if (l2_err) begin
            l2_sts_r[mcec_pkg::L2_LOST_BIT] <= 1'b1;
        end else if (wr_at(mcec_pkg::L2_STS_OFS)) begin
            l2_sts_r <= l2_sts_r & ~w1c[3:0];
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            etm_r <= 1'b0;
        end else if (l2_err) begin
            etm_r <= 1'b1;
        end else if (wr_at(mcec_pkg::L2_CTRL_OFS) && w1c[mcec_pkg::L2C_ETM_BIT]) begin
            etm_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bus_wb_r <= 1'b0;
        end else if (l2_i.flush_wb && (l2_sts_r[2:1] != 2'h0)) begin
            bus_wb_r <= 1'b1;
        end else if (wr_at(mcec_pkg::BUS_STS_OFS) && w1c[mcec_pkg::BUS_WB_BIT]) begin
            bus_wb_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Machine check sequencing
    // ------------------------------------------------------------
    logic str_bad;
    logic async_ev;
    logic sync_ev;
    logic sync_pend_r;
    assign str_bad  = string_move_i && (string_state_i == mcec_pkg::STR_ILLEGAL);
    // TB parity and stall timeout are asynchronous
    assign async_ev = xb_err || tmo_hit;
    // a failed prefetch counts as sync only once its data is used
    assign sync_ev  = str_bad || impossible_addr_i || pte_wr_err_i ||
                      (sync_pend_r && fetch_used_i);
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sync_pend_r <= 1'b0;
        end else if (fetch_err_i) begin
            sync_pend_r <= 1'b1;
        end else if (fetch_used_i || fetch_abandon_i) begin
            sync_pend_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            microtrap_o        <= 1'b0;
            mchk_o             <= 1'b0;
            mchk_code_o        <= 8'h00;
            restartable_flag_o <= 1'b0;
        end else begin
            microtrap_o <= async_ev || pte_wr_err_i;
            mchk_o      <= async_ev || str_bad || impossible_addr_i || pte_wr_err_i ||
                           (sync_pend_r && fetch_used_i);
            if (async_ev) begin
                mchk_code_o        <= mcec_pkg::ASYNC_MCHK_CODE;
                restartable_flag_o <= 1'b0;
            end else if (str_bad) begin
                mchk_code_o        <= mcec_pkg::STRING_STATE_CODE;
                restartable_flag_o <= 1'b0;
            end else if (impossible_addr_i) begin
                mchk_code_o        <= mcec_pkg::IMPOSSIBLE_ADDR_CODE;
                restartable_flag_o <= 1'b0;
            end else if (pte_wr_err_i || (sync_pend_r && fetch_used_i)) begin
                mchk_code_o        <= mcec_pkg::SYNC_MCHK_CODE;
                restartable_flag_o <= !pte_wr_err_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [EV_NUM_W-1:0] ev;
    logic soft_ev;
    logic hard_ev;
    assign soft_ev = (sync_pend_r && fetch_abandon_i && !fetch_used_i) || ic_err ||
                     (l2_err && !l2_locked);
    assign hard_ev = l2_err && l2_locked;
    assign ev = {hard_ev, soft_ev, sync_ev, async_ev};
    generate
        for (genvar g = 0; g < EV_NUM_W; g++) begin : g_ev
            always_ff @(posedge clk_i or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    int_sts_r[g]  <= 1'b0;
                    int_mask_r[g] <= 1'b0;
                end else begin
                    if (ev[g]) begin
                        int_sts_r[g] <= 1'b1;
                    end else if (wr_at(mcec_pkg::INT_STS_OFS) && w1c[g]) begin
                        int_sts_r[g] <= 1'b0;
                    end
                    if (wr_at(mcec_pkg::INT_MASK_OFS)) begin
                        int_mask_r[g] <= pwdata_i[g];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs and read data
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (paddr_i)
            mcec_pkg::XBUF_STS_OFS:  rd_mux = {29'h0, xb_sts_r};
            mcec_pkg::EXEC_CTRL_OFS: rd_mux = {31'h0, ec_tmo_r};
            mcec_pkg::IC_STS_OFS:    rd_mux = {27'h0, ic_sts_r};
            mcec_pkg::IC_VADDR_OFS:  rd_mux = {ic_vaddr_r, 3'h0};
            mcec_pkg::L2_STS_OFS:    rd_mux = {28'h0, l2_sts_r};
            mcec_pkg::L2_IDX_OFS:    rd_mux = {16'h0, l2_idx_r};
            mcec_pkg::L2_SYN_OFS:    rd_mux = {24'h0, l2_syn_r};
            mcec_pkg::L2_CTRL_OFS:   rd_mux = {31'h0, etm_r};
            mcec_pkg::BUS_STS_OFS:   rd_mux = {31'h0, bus_wb_r};
            mcec_pkg::MCHK_INFO_OFS: rd_mux = {23'h0, restartable_flag_o, mchk_code_o};
            mcec_pkg::INT_STS_OFS:   rd_mux = {28'h0, int_sts_r};
            mcec_pkg::INT_MASK_OFS:  rd_mux = {28'h0, int_mask_r};
            default:                 rd_ok  = 1'b0;
        endcase
    end
    // Zero-wait slave: pready is registered from the setup cycle so the access phase completes in one cycle
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !rd_ok;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ic_enable_o             <= 1'b1;
            ic_flush_o              <= 1'b0;
            error_transition_mode_o <= 1'b0;
            irq_o                   <= 1'b0;
        end else begin
            ic_enable_o             <= ic_sts_r[mcec_pkg::IC_EN_BIT];
            ic_flush_o              <= ic_flush_r;
            error_transition_mode_o <= etm_r;
            irq_o                   <= |(int_sts_r & int_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_r);
    xb_trap_a: assert property (xb_err |=> microtrap_o && mchk_o)
        else $error("tb parity without trap");
    xb_lock_a: assert property (xb_sts_r[0] && !(wr_at(8'h00) && w1c[0]) |=> xb_sts_r[0])
        else $error("tb lock dropped");
    tmo_flag_a: assert property (tmo_hit |=> ec_tmo_r ##0 mchk_code_o == 8'h01)
        else $error("timeout flag missing");
    str_chk_a: assert property (str_bad && !async_ev |=> mchk_code_o == 8'h03)
        else $error("string state check missing");
    etm_hold_a: assert property (etm_r && !wr_at(8'h1C) |=> etm_r)
        else $error("etm left early");
    lost_hard_a: assert property (l2_err && l2_locked |=> l2_sts_r[3] && int_sts_r[3])
        else $error("lost without hard");
    idx_hold_a: assert property (l2_locked && !wr_at(8'h10) |=> $stable(l2_idx_r))
        else $error("index changed while locked");
    ic_cap_a: assert property (ic_err && !ic_sts_r[0] |=> ic_vaddr_r == $past(ic_i.qw_vaddr))
        else $error("ic address not captured");
    irq_lvl_a: assert property ((|(int_sts_r & int_mask_r)) |=> irq_o)
        else $error("irq not raised");
    cov_lost_c: cover property (l2_err && l2_locked);
    cov_tmo_c: cover property (tmo_hit);
    cov_soft_c: cover property (sync_pend_r && fetch_abandon_i);

endmodule : mcec_top

// File: testbench/machine_check_error_capture_bench.sv
/* Self-checking bench for mcec_top: table of error events and register reads, then hand tests.
   Assumes APB answers by pready_o and error inputs are taken on clk_i. */
`timescale 1ns/10ps
module machine_check_error_capture_bench;
    // ----------------------------------------
    // Short register names and table rows
    // ----------------------------------------
    localparam logic [7:0] XB = mcec_pkg::XBUF_STS_OFS, EC = mcec_pkg::EXEC_CTRL_OFS,
        IC = mcec_pkg::IC_STS_OFS, IV = mcec_pkg::IC_VADDR_OFS, LS = mcec_pkg::L2_STS_OFS,
        LX = mcec_pkg::L2_IDX_OFS, LY = mcec_pkg::L2_SYN_OFS, LC = mcec_pkg::L2_CTRL_OFS,
        BS = mcec_pkg::BUS_STS_OFS, MI = mcec_pkg::MCHK_INFO_OFS,
        IS = mcec_pkg::INT_STS_OFS, IM = mcec_pkg::INT_MASK_OFS;
    typedef struct packed {
        logic [3:0]  k;
        logic        w;
        logic [7:0]  a;
        logic [31:0] v;
        logic [31:0] m;
    } mcec_row_type;
    // Event k fires first, then the register is written or read under mask m
    mcec_row_type rows [39] = '{'{1,0,XB,3,'hF}, '{0,0,MI,1,'hFF}, '{0,1,XB,1,0},
        '{0,0,XB,2,'hF}, '{0,1,XB,7,0}, '{2,0,XB,5,'hF}, '{0,1,XB,7,0}, '{3,0,MI,3,'hFF},
        '{4,0,MI,4,'hFF}, '{14,0,MI,4,'hFF}, '{11,0,MI,'h102,'h1FF}, '{0,1,IS,'hF,0},
        '{14,0,MI,2,'hFF}, '{12,0,IS,4,'hF}, '{0,1,IS,'hF,0}, '{5,0,IC,'hB,'h1F},
        '{0,0,IV,'h055E6F08,'1}, '{0,0,IS,4,'hF}, '{6,0,IC,'h1B,'h1F},
        '{0,0,IV,'h055E6F08,'1}, '{0,1,IC,'h1F,0}, '{0,0,IC,8,'h1F}, '{0,1,IS,'hF,0},
        '{8,0,LS,3,'hF}, '{0,0,LX,'h1238,'hFFFF}, '{0,0,LY,'h48,'hFF}, '{0,0,IS,4,'hF},
        '{0,1,IS,'hF,0}, '{9,0,LS,'hB,'hF}, '{0,0,LX,'h1238,'hFFFF}, '{0,0,IS,8,'hF},
        '{10,0,BS,1,1}, '{0,1,LS,'hF,0}, '{0,0,LC,1,1}, '{0,1,LC,1,0}, '{0,0,LC,0,1},
        '{9,0,LS,5,'hF}, '{0,1,LS,'hF,0}, '{7,0,LS,5,'hF}};
    logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, stall_s3_i = 0;
    logic string_move_i = 0, impossible_addr_i = 0, fetch_err_i = 0, pte_wr_err_i = 0;
    logic fetch_abandon_i = 0, fetch_used_i = 0, pready_o, pslverr_o, slv, mt, mc;
    logic [1:0] string_state_i = '0;
    logic [7:0] paddr_i = '0, mchk_code_o;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    mcec_pkg::mcec_xbuf_type xbuf_i = '0;
    mcec_pkg::mcec_ic_type ic_i = '0;
    mcec_pkg::mcec_l2_type l2_i = '0;
    logic microtrap_o, mchk_o, restartable_flag_o, ic_enable_o, ic_flush_o;
    logic error_transition_mode_o, irq_o;
    int num_errors = 0, compares = 0;
    mcec_top u_dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .xbuf_i, .stall_s3_i, .string_move_i,
        .string_state_i, .impossible_addr_i, .ic_i, .l2_i, .fetch_err_i, .pte_wr_err_i,
        .fetch_abandon_i, .fetch_used_i, .microtrap_o, .mchk_o, .mchk_code_o,
        .restartable_flag_o, .ic_enable_o, .ic_flush_o, .error_transition_mode_o, .irq_o);
    always #12.5 clk_i = ~clk_i;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until pready_o is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        slv = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
        if (n >= 50) begin
            num_errors++;
            finish_test;
        end
    endtask : apb
    task automatic drive(input logic [3:0] k);
        xbuf_i <= '{k == 1, k == 2};
        string_move_i <= k == 3;
        string_state_i <= (k == 3) ? mcec_pkg::STR_ILLEGAL : 2'h0;
        impossible_addr_i <= k == 4;
        ic_i <= '{k == 5, k == 6, (k == 5) ? 29'h0ABCDE1 : 29'h1111111};
        l2_i <= '{k inside {[7:9]}, 18'h10, (k == 7) ? 18'h10 : 18'h11, k == 9, k == 7,
            16'h1230 + 16'(k), 8'h40 + 8'(k), k == 10};
        {fetch_used_i, fetch_abandon_i} <= {k == 11, k == 12};
        {pte_wr_err_i, fetch_err_i} <= {k == 13, k == 14};
    endtask : drive
    // One-cycle event, then the trap and check pulses one cycle later
    task automatic fire(input logic [3:0] k);
        @(posedge clk_i);
        drive(k);
        @(posedge clk_i);
        drive(4'd0);
        #1 {mt, mc} = {microtrap_o, mchk_o};
    endtask : fire
    task automatic rst;
        arst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : rst
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst;
        foreach (rows[i]) begin
            if (rows[i].k != 0) fire(rows[i].k);
            if (rows[i].k inside {[1:2]}) chk(mt, 1);
            if (rows[i].k inside {[1:4], 11, 12, 14}) chk(mc, rows[i].k < 5 || rows[i].k == 11);
            apb(rows[i].w, rows[i].a, rows[i].v);
            if (!rows[i].w && rows[i].a < LS) chk(rd & rows[i].m, rows[i].v);
            else if (!rows[i].w) chk(rd & rows[i].m, rows[i].v);
        end
        chk(error_transition_mode_o, 1);
        fire(4'd13);
        chk(mt, 1);
        apb(0, 8'h30, 0);
        chk({rd[30:0], slv}, 32'h1);
        apb(1, IS, 'hF);
        apb(1, IM, 'hF);
        fire(4'd4);
        apb(0, IM, 0);
        chk(irq_o, 1);
        apb(1, IM, 0);
        apb(0, IS, 0);
        chk(irq_o, 0);
        apb(1, IS, 'hF);
        apb(0, IS, 0);
        chk({irq_o, rd[3:0]}, 0);
        apb(1, IC, 32'h20);
        @(posedge clk_i);
        #1 chk({ic_enable_o, ic_flush_o}, 2'b01);
        @(posedge clk_i);
        stall_s3_i <= 1'b1;
        repeat (1990) @(posedge clk_i);
        apb(0, EC, 0);
        chk(rd[0], 0);
        repeat (20) @(posedge clk_i);
        apb(0, EC, 0);
        stall_s3_i <= 1'b0;
        chk(rd[0], 1);
        apb(0, IS, 0);
        chk(rd[0], 1);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({ic_enable_o, irq_o, error_transition_mode_o}, 3'b100);
        rst;
        apb(0, IC, 0);
        chk(rd, mcec_pkg::IC_STS_RST);
        finish_test;
    end
endmodule : machine_check_error_capture_bench
